// File: verilog/enclave_entry_exit_control.sv
// Enclave init, launch gating, entry/exit and resume control over APB
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
// Functional notes
// RL1: Fault add/measure after enclave initialized
// RL2: Init fails on bad build, token, signature
// RL3: Init checks run in fixed order
// RL4: Launch enclave produces token first
// RL5: Tokenless launch only if key hash matches
// RL6: Hash registers reset to vendor digest
// RL7: Hash writable only when locked with bit17
// RL8: Busy thread blocks entry with fault
// RL9: Enter sequence steps in fixed order
// RL10: Debug allows steps, else single instruction
// RL11: Leave clears mode, busy, jumps target
// RL12: Leave returns saved async return pointer
// RL13: Software scrubs secrets before leaving
// RL14: Exit event saves state, leaves mode
// RL15: Exit event reports async return pointer
// RL16: Unresolved fault re-raised on resume
// RL17: Resume restores 32 or 64 bits
// RL18: Resume restores features, x87 layout by mode
// RL19: Notify needs flag, slot>0, notify bit
// RL20: Exit increments slot, resume decrements
// RL21: Notification behaves as enter at entry
// RL22: Decrement op lowers current save slot
// RL23: Each op updates state indivisibly
module enclave_entry_exit_control
  import enclave_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire enclave_pkg::apb_req_t apb_req,
  output enclave_pkg::apb_rsp_t      apb_rsp,
  output logic                       enclave_mode,
  output logic                       tlb_flush,
  output logic                       single_step_ok,
  output logic                       wide_restore,
  output logic                       fault
);
  import enclave_pkg::*;

  // ==========================================================
  // State registers
  thread_state_t     st_reg;
  logic [31:0]       operand_reg;
  logic [31:0]       target_reg;
  logic [31:0]       result_reg;
  logic [31:0]       aux_reg;
  logic [31:0]       ret_ptr_reg;
  logic [31:0]       entry_offset_reg;
  logic [31:0]       enc_base_reg;
  logic [31:0]       lock_ctrl_reg;
  logic [31:0]       cfg_reg;
  logic [31:0]       hash_reg [HASH_WORDS];
  logic [31:0]       saved_ext_reg;
  logic [3:0]        fault_reg;
  logic              fault_out_reg;
  logic              flush_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic [31:0]       prdata_reg;

  // ==========================================================
  // APB decode
  wire logic       setup_ph = apb_req.psel && !apb_req.penable;
  // Ready blocks a second take of the same access
  wire logic       access   = apb_req.psel && apb_req.penable && !pready_reg;
  wire logic       wr       = access && apb_req.pwrite;
  wire logic [7:0] addr     = apb_req.paddr;
  // Eight hash words decode as one aligned block
  wire logic       hash_hit = addr[7:5] == REG_HASH_BASE[7:5];
  wire logic [2:0] hash_idx = addr[4:2];
  wire logic       mapped   = hash_hit || addr == REG_CMD ||
                              addr == REG_OPERAND || addr == REG_STATUS ||
                              addr == REG_TARGET || addr == REG_RESULT ||
                              addr == REG_AUX || addr == REG_LOCK_CTRL ||
                              addr == REG_THREAD_CFG ||
                              addr == REG_SLOT_NOTIFY ||
                              addr == REG_ENC_BASE ||
                              addr == REG_MODE_STAT;
  wire logic       cmd_wr   = wr && addr == REG_CMD;
  wire leaf_cmd_t  cmd      = leaf_cmd_t'(apb_req.pwdata[3:0]);
  wire logic       _unused  = setup_ph;

  // Hash writes gated by lock and launch-control bit
  wire logic hash_wr_ok = !cfg_reg[CFG_CAP_LC] ? 1'b0 :
                          lock_ctrl_reg[LOCK_BIT] &&
                          lock_ctrl_reg[LAUNCH_CTRL_BIT]; // RL7
  // Lock register freezes itself once bit 0 is set
  wire logic lock_wr    = wr && addr == REG_LOCK_CTRL &&
                          !lock_ctrl_reg[LOCK_BIT];

  // ==========================================================
  // Notify byte memory
  logic [7:0]        notify_rdata;
  // Notify byte of the frame below the current slot
  // Read data trail a slot change by one clock
  wire logic [SLOT_W-1:0] prev_slot = st_reg.slot - 4'h1;
  wire logic         nb_we   = wr && addr == REG_SLOT_NOTIFY;

  notify_byte_mem u_notify
  (
    .clk   (clk),
    .ce    (ce),
    .we    (nb_we),
    .waddr (apb_req.pwdata[8+SLOT_W-1:8]),
    .wdata (apb_req.pwdata[7:0]),
    .raddr (prev_slot),
    .rdata (notify_rdata)
  );

  // ==========================================================
  // Operand check bits
  wire logic chk_sig   = operand_reg[CHK_SIG_OK];
  wire logic chk_meas  = operand_reg[CHK_MEAS_OK];
  wire logic chk_attr  = operand_reg[CHK_ATTR_OK];
  wire logic launch_ok = operand_reg[CHK_TOKEN_OK] ||
                         operand_reg[CHK_KEY_MATCH]; // RL5
  wire logic resolved  = operand_reg[CHK_RESOLVED];
  wire logic long_mode = cfg_reg[CFG_LONG_MODE] &&
                         cfg_reg[CFG_CODE_LONG]; // RL17
  wire logic notify_ok = cfg_reg[CFG_NOTIFY_EN] &&
                         st_reg.slot != '0 &&
                         notify_rdata[0]; // RL19

  // ==========================================================
  // Leaf operation, one indivisible update per command
  thread_state_t st_next;
  fault_t        flt_next;
  logic [31:0]   result_next;
  logic [31:0]   aux_next;
  logic          flush_next;

  always_comb
  begin
    st_next     = st_reg;
    flt_next    = FLT_NONE;
    result_next = result_reg;
    aux_next    = aux_reg;
    flush_next  = 1'b0;
    case (cmd)
      CMD_ADD, CMD_MEASURE:
        if (st_reg.initialized)
          flt_next = FLT_INITED; // RL1
      // First failing check, in order, names the fault
      CMD_FINALIZE:
        if (st_reg.initialized)
          flt_next = FLT_INITED;
        else if (!chk_sig)
          flt_next = FLT_SIG; // RL2 RL3
        else if (!chk_meas)
          flt_next = FLT_MEAS; // RL3
        else if (!chk_attr)
          flt_next = FLT_ATTR; // RL3
        else if (!launch_ok)
          flt_next = FLT_TOKEN; // RL2 RL5
        else
          st_next.initialized = 1'b1; // RL3
      CMD_ENTER:
        if (!st_reg.initialized)
          flt_next = FLT_NOT_INIT;
        else if (st_reg.busy)
          flt_next = FLT_BUSY; // RL8
        else
        begin
          flush_next            = 1'b1; // RL9
          st_next.enclave_mode  = 1'b1; // RL9
          st_next.single_step_ok = cfg_reg[CFG_DEBUGGABLE] &&
                                   cfg_reg[CFG_DEBUG_REQ]; // RL10
          st_next.busy          = 1'b1; // RL8 RL9
          result_next = enc_base_reg + entry_offset_reg; // RL9
        end
      CMD_LEAVE:
        if (!st_reg.enclave_mode)
          flt_next = FLT_MODE;
        else
        begin
          st_next.enclave_mode = 1'b0; // RL11
          flush_next           = 1'b1; // RL11
          st_next.busy         = 1'b0; // RL11
          result_next          = target_reg; // RL11
          aux_next             = ret_ptr_reg; // RL12
        end
      CMD_EXIT_EVT:
        if (!st_reg.enclave_mode)
          flt_next = FLT_MODE;
        // No free save frame left for this exit
        else if (st_reg.slot == SLOT_W'(NUM_SLOTS - 1))
          flt_next = FLT_SLOT;
        else
        begin
          st_next.enclave_mode = 1'b0; // RL14
          st_next.slot = st_reg.slot + 4'h1; // RL20
          result_next  = ret_ptr_reg; // RL15
        end
      CMD_RESUME:
        if (!st_reg.busy || st_reg.enclave_mode || st_reg.slot == '0)
          flt_next = FLT_SLOT;
        // Notification keeps the slot and the saved frame
        else if (notify_ok)
        begin
          st_next.enclave_mode = 1'b1; // RL21
          st_next.notified     = 1'b1; // RL21
          st_next.single_step_ok = cfg_reg[CFG_DEBUGGABLE] &&
                                   cfg_reg[CFG_DEBUG_REQ]; // RL10 RL21
          flush_next           = 1'b1;
          result_next = {28'h0, st_reg.slot}; // RL21
          aux_next    = operand_reg; // RL21
        end
        else
        begin
          st_next.enclave_mode = 1'b1;
          st_next.notified     = 1'b0;
          st_next.wide_restore = long_mode; // RL17 RL18
          st_next.slot = st_reg.slot - 4'h1; // RL20
          if (!resolved)
            flt_next = FLT_REFAULT; // RL16
        end
      CMD_DEC_SLOT:
        if (st_reg.slot == '0)
          flt_next = FLT_SLOT;
        else
          st_next.slot = st_reg.slot - 4'h1; // RL22
      default:
        flt_next = FLT_NONE;
    endcase
  end

  // ==========================================================
  // Read mux
  logic [31:0] rd_data;
  always_comb
  begin
    // Command register is write-only and reads as UNMAPPED_READ without an error
    rd_data = UNMAPPED_READ;
    if (hash_hit)
      rd_data = hash_reg[hash_idx];
    else
      case (addr)
        REG_OPERAND:     rd_data = operand_reg;
        REG_STATUS:      rd_data = {24'h0, fault_reg, 4'h0};
        REG_TARGET:      rd_data = target_reg;
        REG_RESULT:      rd_data = result_reg;
        REG_AUX:         rd_data = aux_reg;
        REG_LOCK_CTRL:   rd_data = lock_ctrl_reg;
        REG_THREAD_CFG:  rd_data = cfg_reg;
        REG_SLOT_NOTIFY: rd_data = {24'h0, notify_rdata};
        REG_ENC_BASE:    rd_data = enc_base_reg;
        REG_MODE_STAT:   rd_data = {22'h0, st_reg};
        default:         rd_data = UNMAPPED_READ;
      endcase
  end

  // ==========================================================
  // Hash registers
  genvar gi;
  generate
    for (gi = 0; gi < HASH_WORDS; gi++)
    begin : g_hash
      always_ff @(posedge clk)
      begin
        if (rst)
          // Reset digest, word index in the low bits
          hash_reg[gi] <= HASH_RESET_WORD | 32'(gi); // RL6
        else if (ce && wr && hash_hit && hash_idx == 3'(gi) && hash_wr_ok)
          hash_reg[gi] <= apb_req.pwdata; // RL7
      end
    end
  endgenerate

  // ==========================================================
  // Control and bus registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg           <= '0;
      operand_reg      <= RESET_ZERO;
      target_reg       <= RESET_ZERO;
      result_reg       <= RESET_ZERO;
      aux_reg          <= RESET_ZERO;
      ret_ptr_reg      <= RESET_ZERO;
      entry_offset_reg <= RESET_ZERO;
      enc_base_reg     <= RESET_ZERO;
      lock_ctrl_reg    <= RESET_ZERO;
      cfg_reg          <= RESET_ZERO;
      saved_ext_reg    <= RESET_ZERO;
      fault_reg        <= FLT_NONE;
      fault_out_reg    <= 1'b0;
      flush_reg        <= 1'b0;
      pready_reg       <= 1'b0;
      pslverr_reg      <= 1'b0;
      prdata_reg       <= RESET_ZERO;
    end
    // All state holds while ce is low
    else if (ce)
    begin
      // One wait state: ready follows the take
      pready_reg  <= access;
      pslverr_reg <= access && !mapped;
      // Read data stand only with ready
      prdata_reg  <= (access && !apb_req.pwrite) ? rd_data : RESET_ZERO;
      // Pulses, one clock while ce stays high
      flush_reg   <= cmd_wr && flush_next;
      fault_out_reg <= cmd_wr && flt_next != FLT_NONE;
      if (cmd_wr)
      begin
        st_reg     <= st_next; // RL23
        fault_reg  <= flt_next;
        result_reg <= result_next;
        aux_reg    <= aux_next;
        // Entry records the pointer that leave hands back
        if (cmd == CMD_ENTER && flt_next == FLT_NONE)
        begin
          ret_ptr_reg   <= operand_reg; // RL12
          saved_ext_reg <= target_reg; // RL9
        end
      end
      if (wr && addr == REG_OPERAND)
        operand_reg <= apb_req.pwdata;
      if (wr && addr == REG_TARGET)
        target_reg <= apb_req.pwdata;
      if (wr && addr == REG_AUX)
        entry_offset_reg <= apb_req.pwdata;
      if (wr && addr == REG_ENC_BASE)
        enc_base_reg <= apb_req.pwdata;
      if (wr && addr == REG_THREAD_CFG)
        cfg_reg <= apb_req.pwdata;
      if (lock_wr)
        lock_ctrl_reg <= apb_req.pwdata;
    end
  end

  // ==========================================================
  // Outputs
  assign apb_rsp.pready  = pready_reg;
  assign apb_rsp.pslverr = pslverr_reg;
  assign apb_rsp.prdata  = prdata_reg;
  assign enclave_mode    = st_reg.enclave_mode;
  assign single_step_ok  = st_reg.single_step_ok;
  assign wide_restore    = st_reg.wide_restore;
  assign tlb_flush       = flush_reg;
  assign fault           = fault_out_reg;
endmodule

// File: pkg/enclave_pkg.sv
// Package: register map, fields, commands and types for enclave control
package enclave_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] REG_CMD         = 8'h00;
  localparam logic [7:0] REG_OPERAND     = 8'h04;
  localparam logic [7:0] REG_STATUS      = 8'h08;
  localparam logic [7:0] REG_TARGET      = 8'h0C;
  localparam logic [7:0] REG_RESULT      = 8'h10;
  localparam logic [7:0] REG_AUX         = 8'h14;
  localparam logic [7:0] REG_LOCK_CTRL   = 8'h18;
  localparam logic [7:0] REG_HASH_BASE   = 8'h20;
  localparam logic [7:0] REG_THREAD_CFG  = 8'h40;
  localparam logic [7:0] REG_SLOT_NOTIFY = 8'h44;
  localparam logic [7:0] REG_ENC_BASE    = 8'h48;
  localparam logic [7:0] REG_MODE_STAT   = 8'h4C;

  // ==========================================================
  // Field positions
  localparam int LOCK_BIT          = 0;
  localparam int LAUNCH_CTRL_BIT   = 17;
  localparam int HASH_WORDS        = 8;
  localparam int SLOT_W            = 4;
  localparam int NUM_SLOTS         = 16;
  // Thread config bits
  localparam int CFG_NOTIFY_EN     = 0;
  localparam int CFG_DEBUGGABLE    = 1;
  localparam int CFG_DEBUG_REQ     = 2;
  localparam int CFG_LONG_MODE     = 3;
  localparam int CFG_CODE_LONG     = 4;
  localparam int CFG_CAP_LC        = 5;
  // Check inputs written with the init or resume command operand
  localparam int CHK_SIG_OK        = 0;
  localparam int CHK_MEAS_OK       = 1;
  localparam int CHK_ATTR_OK       = 2;
  localparam int CHK_TOKEN_OK      = 3;
  localparam int CHK_KEY_MATCH     = 4;
  localparam int CHK_RESOLVED      = 5;

  // ==========================================================
  // Reset values
  localparam logic [31:0] HASH_RESET_WORD = 32'h5A5A_0000;
  localparam logic [31:0] RESET_ZERO      = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;

  // ==========================================================
  // Commands
  typedef enum logic [3:0]
  {
    CMD_NONE     = 4'h0,
    CMD_ADD      = 4'h1,
    CMD_MEASURE  = 4'h2,
    CMD_FINALIZE = 4'h3,
    CMD_ENTER    = 4'h4,
    CMD_LEAVE    = 4'h5,
    CMD_EXIT_EVT = 4'h6,
    CMD_RESUME   = 4'h7,
    CMD_DEC_SLOT = 4'h8
  } leaf_cmd_t;

  // Fault codes
  typedef enum logic [3:0]
  {
    FLT_NONE      = 4'h0,
    FLT_INITED    = 4'h1,
    FLT_NOT_INIT  = 4'h2,
    FLT_BUSY      = 4'h3,
    FLT_SIG       = 4'h4,
    FLT_MEAS      = 4'h5,
    FLT_ATTR      = 4'h6,
    FLT_TOKEN     = 4'h7,
    FLT_MODE      = 4'h8,
    FLT_SLOT      = 4'h9,
    FLT_REFAULT   = 4'hA
  } fault_t;

  typedef struct packed
  {
    logic        initialized;
    logic        busy;
    logic        enclave_mode;
    logic        single_step_ok;
    logic        wide_restore;
    logic        notified;
    logic [SLOT_W-1:0] slot;
  } thread_state_t;

  typedef struct packed
  {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed
  {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

endpackage

// File: verilog/notify_byte_mem.sv
// Notify-byte memory: one byte per save slot, registered read
`timescale 1ns/1ns
module notify_byte_mem
  import enclave_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              ce,
  input  wire logic              we,
  input  wire logic [SLOT_W-1:0] waddr,
  input  wire logic [7:0]        wdata,
  input  wire logic [SLOT_W-1:0] raddr,
  output logic      [7:0]        rdata
);
  logic [7:0] mem [NUM_SLOTS];

  always_ff @(posedge clk)
  begin
    if (ce && we)
      mem[waddr] <= wdata;
    if (ce)
      rdata <= mem[raddr];
  end
endmodule

// File: dv/enclave_chk.sv
// Checker: port-level timing relations of the enclave control block
`timescale 1ns/1ns
module enclave_chk
  import enclave_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  ce,
  input wire enclave_pkg::apb_req_t apb_req,
  input wire enclave_pkg::apb_rsp_t apb_rsp,
  input wire logic                  enclave_mode,
  input wire logic                  tlb_flush,
  input wire logic                  single_step_ok,
  input wire logic                  wide_restore,
  input wire logic                  fault
);
  // Reset seen one clock late keeps checks off while outputs settle
  logic rst_q;
  always_ff @(posedge clk)
    rst_q <= rst;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst || rst_q);

  // ==========================================================
  // Decode of the held request
  wire       taken = ce && apb_req.psel && apb_req.penable && !apb_rsp.pready;
  wire       cmd_w = apb_req.psel && apb_req.pwrite && apb_req.paddr == REG_CMD;
  wire       done  = apb_rsp.pready && cmd_w;
  wire [3:0] op    = apb_req.pwdata[3:0];

  // ==========================================================
  // Assertions
  a_fault_cause: assert property (fault |-> done)
    else $error("fault pulse without a finished command");
  a_flush_cause: assert property (tlb_flush |-> done &&
    op inside {CMD_ENTER, CMD_LEAVE, CMD_RESUME})
    else $error("flush pulse without enter, leave or resume");
  a_enter_mode: assert property (done && op == CMD_ENTER && !fault
    |-> enclave_mode && tlb_flush)
    else $error("enter did not set mode and flush");
  a_leave_exit: assert property (done && op == CMD_LEAVE && !fault
    |-> !enclave_mode && tlb_flush)
    else $error("leave did not clear mode and flush");
  a_aex_exit: assert property (done && op == CMD_EXIT_EVT && !fault
    |-> !enclave_mode)
    else $error("exit event left enclave mode set");
  a_busy_fault: assert property (taken && cmd_w && op == CMD_ENTER
    && enclave_mode |=> fault)
    else $error("entry through busy thread not faulted");
  a_one_wait: assert property (taken |=> apb_rsp.pready ##1
    !apb_rsp.pready)
    else $error("ready not a single pulse after one wait");
  a_mode_cause: assert property ($changed(enclave_mode) |-> done)
    else $error("mode changed outside a command");
  a_step_cause: assert property ($rose(single_step_ok) |-> done &&
    op inside {CMD_ENTER, CMD_RESUME})
    else $error("debug stepping enabled outside entry");
  a_wide_cause: assert property ($changed(wide_restore) |->
    done && op == CMD_RESUME)
    else $error("restore width changed outside resume");
endmodule

// File: dv/leaf_issuer.sv
// Software side model: issues register and leaf operations over APB
`timescale 1ns/1ns
module leaf_issuer
  import enclave_pkg::*;
(
  input  wire logic                  clk,
  output enclave_pkg::apb_req_t      apb_req,
  input  wire enclave_pkg::apb_rsp_t apb_rsp
);
  initial apb_req = '0;

  // ==========================================================
  // One APB transfer, held until ready is sampled
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do
      @(posedge clk);
    while (apb_rsp.pready !== 1'b1);
    // Released data inverted so stale values never look valid
    apb_req <= '{1'b0, 1'b0, w, a, ~d};
  endtask
endmodule

// File: dv/tb_enclave_entry_exit_control.sv
// Testbench: self-checking run of the enclave entry and exit control
`timescale 1ns/1ns
module tb_enclave_entry_exit_control;
  import enclave_pkg::*;
  typedef struct packed
  {
    logic        err;
    logic [31:0] mask;
    logic [31:0] data;
  } note_t;

  logic     clk = 1'b0;
  logic     rst = 1'b1;
  logic     ce  = 1'b1;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  logic     enclave_mode;
  logic     tlb_flush;
  logic     single_step_ok;
  logic     wide_restore;
  logic     fault;
  note_t    exp_q[$];
  note_t    e;
  int       miscompares = 0;
  int       cmp_count = 0;
  int       seed = 20;
  logic [31:0] v;
  logic [31:0] rp;
  logic [31:0] b;
  logic [31:0] o;
  logic [31:0] ops[4] = '{32'h0, 32'h1, 32'h3, 32'h7};
  fault_t      flts[4] = '{FLT_SIG, FLT_MEAS, FLT_ATTR, FLT_TOKEN};
  logic [31:0] cfgs[4] = '{32'h20, 32'h28, 32'h30, 32'h38};

  always #20 clk = ~clk;

  enclave_entry_exit_control dut (.clk(clk), .rst(rst), .ce(ce),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .enclave_mode(enclave_mode),
    .tlb_flush(tlb_flush), .single_step_ok(single_step_ok),
    .wide_restore(wide_restore), .fault(fault));
  leaf_issuer m (.clk(clk), .apb_req(apb_req), .apb_rsp(apb_rsp));

  // ==========================================================
  // Comparison, verdict and helpers
  task automatic chk(input logic [32:0] s, input logic [32:0] x);
    cmp_count++;
    if (s !== x)
    begin
      miscompares++;
      $display("Error %0t seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic summarize();
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] k,
                     input logic [31:0] x, input logic er = 1'b0);
    exp_q.push_back('{er, k, x});
    m.xfer(1'b0, a, 32'h0);
  endtask

  task automatic cmd(input leaf_cmd_t c);
    wr(REG_CMD, {28'h0, c});
  endtask

  task automatic chk_st(input fault_t f);
    rdm(REG_STATUS, 32'h000000F0, {24'h0, f, 4'h0});
  endtask

  // ==========================================================
  // Read monitor: oldest note against each read answer
  always @(posedge clk)
    if (apb_rsp.pready === 1'b1 && apb_req.pwrite === 1'b0)
    begin
      e = exp_q.pop_front();
      chk({apb_rsp.pslverr, apb_rsp.prdata & e.mask}, {e.err, e.data});
    end

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    summarize();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < HASH_WORDS; i++)
      rdm(REG_HASH_BASE + 8'(4 * i), '1, HASH_RESET_WORD | i);
    v = $random(seed);
    wr(REG_HASH_BASE, v);
    rdm(REG_HASH_BASE, '1, HASH_RESET_WORD);
    wr(REG_THREAD_CFG, 32'h20);
    wr(REG_LOCK_CTRL, 32'h00020000);
    wr(REG_HASH_BASE, v);
    rdm(REG_HASH_BASE, '1, HASH_RESET_WORD);
    wr(REG_LOCK_CTRL, 32'h00020001);
    wr(REG_HASH_BASE + 8'h04, v);
    rdm(REG_HASH_BASE + 8'h04, '1, v);
    wr(REG_LOCK_CTRL, 32'h0);
    rdm(REG_LOCK_CTRL, '1, 32'h00020001);
    rdm(8'hFC, '1, UNMAPPED_READ, 1'b1);
    // Failing checks report the earliest step in order
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_OPERAND, ops[i]);
      cmd(CMD_FINALIZE);
      chk_st(flts[i]);
    end
    wr(REG_OPERAND, 32'h17);
    cmd(CMD_FINALIZE);
    chk_st(FLT_NONE);
    rdm(REG_MODE_STAT, 32'h200, 32'h200);
    cmd(CMD_ADD);
    chk_st(FLT_INITED);
    cmd(CMD_MEASURE);
    chk_st(FLT_INITED);
    b = $random(seed);
    o = $random(seed);
    rp = $random(seed);
    wr(REG_THREAD_CFG, 32'h26);
    wr(REG_ENC_BASE, b);
    wr(REG_AUX, o);
    wr(REG_OPERAND, rp);
    cmd(CMD_ENTER);
    chk_st(FLT_NONE);
    rdm(REG_RESULT, '1, b + o);
    chk({32'h0, single_step_ok}, 33'h1);
    rdm(REG_MODE_STAT, 32'h180, 32'h180);
    cmd(CMD_ENTER);
    chk_st(FLT_BUSY);
    v = $random(seed);
    wr(REG_TARGET, v);
    wr(REG_OPERAND, 32'h0);
    cmd(CMD_LEAVE);
    rdm(REG_RESULT, '1, v);
    rdm(REG_AUX, '1, rp);
    rdm(REG_MODE_STAT, 32'h180, 32'h0);
    rp = $random(seed);
    wr(REG_THREAD_CFG, 32'h38);
    wr(REG_OPERAND, rp);
    cmd(CMD_ENTER);
    chk({32'h0, single_step_ok}, 33'h0);
    cmd(CMD_EXIT_EVT);
    rdm(REG_RESULT, '1, rp);
    rdm(REG_MODE_STAT, 32'h8F, 32'h01);
    // Restore width follows both mode bits
    for (int i = 0; i < 4; i++)
    begin
      if (i > 0)
        cmd(CMD_EXIT_EVT);
      wr(REG_THREAD_CFG, cfgs[i]);
      wr(REG_OPERAND, 32'h20);
      cmd(CMD_RESUME);
      chk({32'h0, wide_restore}, {32'h0, cfgs[i] == 32'h38});
      rdm(REG_MODE_STAT, 32'h8F, 32'h80);
    end
    o = $random(seed);
    wr(REG_THREAD_CFG, 32'h21);
    cmd(CMD_EXIT_EVT);
    wr(REG_SLOT_NOTIFY, 32'h00000001);
    wr(REG_OPERAND, o);
    cmd(CMD_RESUME);
    rdm(REG_RESULT, '1, 32'h1);
    rdm(REG_AUX, '1, o);
    rdm(REG_MODE_STAT, 32'h8F, 32'h81);
    // Clock enable low stretches the access, one decrement only
    fork
      cmd(CMD_DEC_SLOT);
      begin
        @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        chk({32'h0, apb_rsp.pready}, 33'h0);
        ce <= 1'b1;
      end
    join
    rdm(REG_MODE_STAT, 32'h0F, 32'h0);
    cmd(CMD_EXIT_EVT);
    wr(REG_SLOT_NOTIFY, 32'h0);
    wr(REG_OPERAND, 32'h20);
    cmd(CMD_RESUME);
    rdm(REG_MODE_STAT, 32'h8F, 32'h80);
    cmd(CMD_EXIT_EVT);
    wr(REG_OPERAND, 32'h0);
    cmd(CMD_RESUME);
    chk_st(FLT_REFAULT);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdm(REG_HASH_BASE + 8'h04, '1, HASH_RESET_WORD | 32'h1);
    rdm(REG_MODE_STAT, 32'h3FF, 32'h0);
    cmd(CMD_ENTER);
    chk_st(FLT_NOT_INIT);
    cmd(CMD_LEAVE);
    chk_st(FLT_MODE);
    cmd(CMD_DEC_SLOT);
    chk_st(FLT_SLOT);
    wr(REG_OPERAND, 32'h0F);
    cmd(CMD_FINALIZE);
    chk_st(FLT_NONE);
    repeat (2) @(posedge clk);
    summarize();
  end
endmodule

bind enclave_entry_exit_control enclave_chk chk_i (.clk(clk), .rst(rst),
  .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .enclave_mode(enclave_mode), .tlb_flush(tlb_flush),
  .single_step_ok(single_step_ok), .wide_restore(wide_restore),
  .fault(fault));
